// >>> hdl/eivs_sense.sv
// Purpose: sense detector for one dedicated interrupt input
// Assumes: pin already synchronised to ref_clk
// Notes: level mode gives a request, never a sticky flag
`timescale 1ns/10ps
`default_nettype none
module eivs_sense (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic pin_sync,
	input wire eivs_pkg::eivs_sense_type mode,
	output logic edge_hit,
	output logic level_hit
);
	import eivs_pkg::*;

	logic prev_q;
	logic prev_d;

	always_comb begin
		prev_d = clk_en ? pin_sync : prev_q;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= prev_d;
		end
	end

	always_comb begin
		edge_hit = 1'b0;
		case (mode)
			eivs_sense_any: edge_hit = prev_q ^ pin_sync;
			eivs_sense_fall: edge_hit = prev_q & ~pin_sync;
			eivs_sense_rise: edge_hit = ~prev_q & pin_sync;
			default: edge_hit = 1'b0;
		endcase
		edge_hit = edge_hit & clk_en;
		level_hit = (mode == eivs_sense_low) & ~pin_sync;
	end
endmodule : eivs_sense
`default_nettype wire

// >>> hdl/eivs_sync.sv
// Purpose: two-stage synchroniser for a vector of pins
// Assumes: pins may change at any time
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module eivs_sync #(
	parameter int WIDTH = 35
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] stab_q;
	logic [WIDTH-1:0] stab_d;

	always_comb begin
		meta_d = clk_en ? pin_in : meta_q;
		stab_d = clk_en ? meta_q : stab_q;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= '0;
			stab_q <= '0;
		end else begin
			meta_q <= meta_d;
			stab_q <= stab_d;
		end
	end

	assign pin_out = stab_q;
endmodule : eivs_sync
`default_nettype wire

// >>> hdl/eivs_top.sv
// Purpose: external interrupt front end and protected vector placement
// Assumes: ref_clk 250 MHz, rst synchronous active high, avalon-mm slave
// Notes: core-side handshakes arrive as one-cycle pulses
//
// What this block does
// - vector_select zero: vectors at flash start; one: boot section.
// - gated from change-enable until one instruction past select, or 4.
// - suppression never alters the global interrupt enable bit.
// - change-enable clears itself after four cycles or on select write.
// - lock bits block interrupts while running from the other section.
// - group request n fires on any enabled toggle in its eight inputs.
// - pin-change detection needs clk_en running; pc_wake comes from the group flag.
// - inputs trigger even when the pin is driven as an output.
// - two-bit sense per input: low, any edge, falling, rising.
// - low-level sense requests as long as the pin stays low.
// - only low-level dedicated detection works while the I/O clock is halted.
// - low-level wake gives an interrupt only if level outlasts start-up.
// - dedicated input serviced only with its enable and global enable.
// - sense control bits 7:6 always read zero.
// - pulses wider than the minimum width always produce an interrupt.
// - input flag set on trigger, cleared by handler or writing one.
// - each pin-change input counts only with its mask bit set.
// - group flag set on masked change, cleared by handler or one.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "eivs_map.svh"
module eivs_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire eivs_pkg::eivs_bus_req_type bus_req,
	output eivs_pkg::eivs_bus_rsp_type bus_rsp,
	input wire logic [2:0] dedicated_irq_inputs,
	input wire logic [31:0] pin_change_inputs,
	input wire logic global_irq_enable,
	input wire logic insn_retire,
	input wire logic exec_in_boot,
	input wire logic application_lock_bit,
	input wire logic boot_lock_bit,
	input wire logic [2:0] ded_ack,
	input wire logic [3:0] pc_ack,
	output logic vector_select,
	output logic [2:0] ded_request,
	output logic [3:0] pc_request,
	output logic [2:0] ded_wake,
	output logic [3:0] pc_wake
);
	import eivs_pkg::*;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [2:0] enable_q, enable_d;
	logic [5:0] sense_q, sense_d;
	logic [2:0] ext_flag_q, ext_flag_d;
	logic [3:0] pc_flag_q, pc_flag_d;
	logic [3:0] pc_ctrl_q, pc_ctrl_d;
	logic [7:0] pc_mask_q [4];
	logic [7:0] pc_mask_d [4];
	logic vsel_q, vsel_d;
	logic vce_q, vce_d;
	logic [2:0] vce_cnt_q, vce_cnt_d;
	eivs_vc_state_type vc_q, vc_d;
	logic [31:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] pc_prev_q, pc_prev_d;

	// ----------------------------------------
	// synchronised pins
	// ----------------------------------------
	logic [34:0] sync_out;
	logic [2:0] ded_s;
	logic [31:0] pc_s;
	logic [2:0] edge_hit;
	logic [2:0] level_hit;

	// the pins are read straight, whatever their direction
	eivs_sync #(.WIDTH(35)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.pin_in({dedicated_irq_inputs, pin_change_inputs}),
		.pin_out(sync_out)
	);

	assign ded_s = sync_out[34:32];
	assign pc_s = sync_out[31:0];

	for (genvar g = 0; g < `EIVS_NUM_DED; g++) begin : g_sense
		eivs_sense u_sense (
			.ref_clk(ref_clk),
			.rst(rst),
			.clk_en(clk_en),
			.pin_sync(ded_s[g]),
			.mode(eivs_sense_type'(sense_q[2*g +: 2])),
			.edge_hit(edge_hit[g]),
			.level_hit(level_hit[g])
		);
	end

	// ----------------------------------------
	// bus decode helpers
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
		hit = (a == idx);
	endfunction : hit

	logic wr;
	logic rd;
	logic [7:0] wb;
	assign wr = bus_req.write & clk_en;
	assign rd = bus_req.read & clk_en;
	assign wb = bus_req.writedata[7:0];

	// ----------------------------------------
	// pin-change detection
	// ----------------------------------------
	logic [3:0] pc_event;
	always_comb begin
		pc_prev_d = clk_en ? pc_s : pc_prev_q;
		for (int i = 0; i < 4; i++) begin
			// any masked toggle in the group
			pc_event[i] = clk_en &
				(|((pc_s[8*i +: 8] ^ pc_prev_q[8*i +: 8]) & pc_mask_q[i]));
		end
	end

	// ----------------------------------------
	// register next values
	// ----------------------------------------
	logic vsel_wr;
	logic core_wr;
	assign core_wr = wr & hit(bus_req.address, `EIVS_IDX_CORE);
	// select only moves while change-enable is open, with vce written zero
	assign vsel_wr = core_wr & vce_q & ~wb[`EIVS_CORE_VCE];

	always_comb begin
		enable_d = enable_q;
		sense_d = sense_q;
		pc_ctrl_d = pc_ctrl_q;
		pc_mask_d = pc_mask_q;
		vsel_d = vsel_q;
		if (wr && hit(bus_req.address, `EIVS_IDX_ENABLE)) begin
			enable_d = wb[2:0];
		end else if (wr && hit(bus_req.address, `EIVS_IDX_SENSE)) begin
			sense_d = wb[`EIVS_SENSE_BITS-1:0];
		end else if (wr && hit(bus_req.address, `EIVS_IDX_PC_CTRL)) begin
			pc_ctrl_d = wb[3:0];
		end else if (wr && bus_req.address >= `EIVS_IDX_PC_MASK0 &&
				bus_req.address <= `EIVS_IDX_PC_MASK3) begin
			pc_mask_d[2'(bus_req.address - `EIVS_IDX_PC_MASK0)] = wb;
		end
		if (vsel_wr) begin
			vsel_d = wb[`EIVS_CORE_VSEL];
		end
	end

	// flags: a hardware set wins over a clear in the same cycle
	always_comb begin
		ext_flag_d = ext_flag_q;
		pc_flag_d = pc_flag_q;
		if (wr && hit(bus_req.address, `EIVS_IDX_EXT_FLAG)) begin
			ext_flag_d = ext_flag_d & ~wb[2:0];
		end
		if (wr && hit(bus_req.address, `EIVS_IDX_PC_FLAG)) begin
			pc_flag_d = pc_flag_d & ~wb[3:0];
		end
		ext_flag_d = ext_flag_d & ~ded_ack;
		pc_flag_d = pc_flag_d & ~pc_ack;
		ext_flag_d = ext_flag_d | edge_hit;
		pc_flag_d = pc_flag_d | pc_event;
		for (int i = 0; i < 3; i++) begin
			if (sense_q[2*i +: 2] == 2'b00) begin
				ext_flag_d[i] = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// vector change window
	// ----------------------------------------
	always_comb begin
		vc_d = vc_q;
		vce_d = vce_q;
		vce_cnt_d = vce_cnt_q;
		case (vc_q)
			eivs_vc_idle: begin
				if (core_wr && wb[`EIVS_CORE_VCE]) begin
					vc_d = eivs_vc_open;
					vce_d = 1'b1;
					vce_cnt_d = `EIVS_VCE_CYCLES;
				end
			end
			eivs_vc_open: begin
				if (vsel_wr) begin
					vce_d = 1'b0;
					vc_d = eivs_vc_trail;
				end else if (clk_en && vce_cnt_q == 3'd1) begin
					vce_d = 1'b0;
					vc_d = eivs_vc_idle;
				end else if (clk_en) begin
					vce_cnt_d = vce_cnt_q - 3'd1;
				end
			end
			eivs_vc_trail: begin
				// hold off until the instruction after the select write retires
				if (clk_en && insn_retire) begin
					vc_d = eivs_vc_idle;
				end
			end
			default: vc_d = eivs_vc_idle;
		endcase
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		rdata_d = 32'h0000_0000;
		rvalid_d = 1'b0;
		if (rd && !rvalid_q) begin
			rvalid_d = 1'b1;
			if (hit(bus_req.address, `EIVS_IDX_ENABLE)) begin
				rdata_d[2:0] = enable_q;
			end else if (hit(bus_req.address, `EIVS_IDX_CORE)) begin
				rdata_d[`EIVS_CORE_VSEL] = vsel_q;
				rdata_d[`EIVS_CORE_VCE] = vce_q;
			end else if (hit(bus_req.address, `EIVS_IDX_SENSE)) begin
				rdata_d[5:0] = sense_q;
			end else if (hit(bus_req.address, `EIVS_IDX_EXT_FLAG)) begin
				rdata_d[2:0] = ext_flag_q;
			end else if (hit(bus_req.address, `EIVS_IDX_PC_FLAG)) begin
				rdata_d[3:0] = pc_flag_q;
			end else if (hit(bus_req.address, `EIVS_IDX_PC_CTRL)) begin
				rdata_d[3:0] = pc_ctrl_q;
			end else if (bus_req.address >= `EIVS_IDX_PC_MASK0 &&
					bus_req.address <= `EIVS_IDX_PC_MASK3) begin
				rdata_d[7:0] = pc_mask_q[2'(bus_req.address - `EIVS_IDX_PC_MASK0)];
			end
		end else if (!clk_en) begin
			rdata_d = rdata_q;
			rvalid_d = rvalid_q;
		end
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			enable_q <= 3'h0;
			sense_q <= 6'h00;
			ext_flag_q <= 3'h0;
			pc_flag_q <= 4'h0;
			pc_ctrl_q <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				pc_mask_q[i] <= `EIVS_RESET_BYTE;
			end
			vsel_q <= 1'b0;
			vce_q <= 1'b0;
			vce_cnt_q <= 3'h0;
			vc_q <= eivs_vc_idle;
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
			pc_prev_q <= 32'h0000_0000;
		end else if (clk_en) begin
			enable_q <= enable_d;
			sense_q <= sense_d;
			ext_flag_q <= ext_flag_d;
			pc_flag_q <= pc_flag_d;
			pc_ctrl_q <= pc_ctrl_d;
			pc_mask_q <= pc_mask_d;
			vsel_q <= vsel_d;
			vce_q <= vce_d;
			vce_cnt_q <= vce_cnt_d;
			vc_q <= vc_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			pc_prev_q <= pc_prev_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic suppress;
	logic lock_block;
	// suppression gates requests only; the global enable is an input here
	assign suppress = (vc_q != eivs_vc_idle);
	assign lock_block = (vsel_q & application_lock_bit & ~exec_in_boot) |
		(~vsel_q & boot_lock_bit & exec_in_boot);

	logic gate;
	assign gate = global_irq_enable & ~suppress & ~lock_block;
	// level requests follow the pin live, so a level gone before start-up
	// ends leaves nothing pending
	assign ded_request = (ext_flag_q | level_hit) & enable_q &
		{3{gate}};
	assign pc_request = pc_flag_q & pc_ctrl_q & {4{gate}};
	// low-level wake uses the raw pin; limitation: edges are sampled, so
	// pulses must span one ref_clk period to be caught
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			ded_wake[i] = enable_q[i] & ((sense_q[2*i +: 2] == 2'b00) ?
				~dedicated_irq_inputs[i] : ext_flag_q[i]);
		end
		for (int i = 0; i < 4; i++) begin
			pc_wake[i] = pc_ctrl_q[i] & pc_flag_q[i];
		end
	end

	assign vector_select = vsel_q;
	assign bus_rsp.readdata = rdata_q;
	assign bus_rsp.waitrequest = bus_req.read & ~rvalid_q;
endmodule : eivs_top
`default_nettype wire

// >>> shared/eivs_map.svh
// Purpose: offsets, field positions, reset values and counts of the block
// Assumes: word-index addresses on a 32-bit avalon bus
// Notes: the seven offsets not printed for this block are placed from 0x80 up
`ifndef EIVS_MAP_SVH
`define EIVS_MAP_SVH

`define EIVS_IDX_ENABLE 8'h1d
`define EIVS_IDX_CORE 8'h35
`define EIVS_IDX_SENSE 8'h69
`define EIVS_IDX_EXT_FLAG 8'h80
`define EIVS_IDX_PC_FLAG 8'h81
`define EIVS_IDX_PC_CTRL 8'h82
`define EIVS_IDX_PC_MASK0 8'h83
`define EIVS_IDX_PC_MASK3 8'h86

`define EIVS_CORE_VSEL 1
`define EIVS_CORE_VCE 0
`define EIVS_SENSE_BITS 6
`define EIVS_RESET_BYTE 8'h00
`define EIVS_VCE_CYCLES 3'd4
`define EIVS_NUM_DED 3
`define EIVS_NUM_PC 32

`endif

// >>> shared/eivs_pkg.sv
// Purpose: types shared by the external interrupt block
// Assumes: eivs_map.svh holds the numbers
// Notes: none
package eivs_pkg;
	typedef enum logic [1:0] {
		eivs_sense_low,
		eivs_sense_any,
		eivs_sense_fall,
		eivs_sense_rise
	} eivs_sense_type;

	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} eivs_bus_req_type;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} eivs_bus_rsp_type;

	typedef enum logic [1:0] {
		eivs_vc_idle,
		eivs_vc_open,
		eivs_vc_trail
	} eivs_vc_state_type;
endpackage : eivs_pkg

// >>> verif/eivs_pins.sv
// Purpose: board-level drivers on the interrupt pins
// Assumes: bench calls the tasks just after a clock edge
// Notes: a level holds until told otherwise
`timescale 1ns/10ps
`default_nettype none
module eivs_pins (
	output logic [2:0] dedicated_irq_inputs,
	output logic [31:0] pin_change_inputs
);
	initial begin
		dedicated_irq_inputs = 3'h7;
		pin_change_inputs = 32'h0;
	end
	// levels stay for many cycles, well past one instruction
	task automatic set_ded(input int i, input logic v);
		dedicated_irq_inputs[i] <= v;
	endtask : set_ded
	task automatic flip_pc(input int i);
		pin_change_inputs[i] <= ~pin_change_inputs[i];
	endtask : flip_pc
endmodule : eivs_pins
`default_nettype wire

// >>> verif/eivs_props.sv
// Purpose: assertions on vector move, request gating and readback
// Assumes: one clock, synchronous active-high reset
// Notes: cnt_q mirrors the four-cycle change window, conservatively
`timescale 1ns/10ps
`default_nettype none
`include "eivs_map.svh"
module eivs_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire eivs_pkg::eivs_bus_req_type bus_req,
	input wire eivs_pkg::eivs_bus_rsp_type bus_rsp,
	input wire logic exec_in_boot,
	input wire logic application_lock_bit,
	input wire logic boot_lock_bit,
	input wire logic vector_select,
	input wire logic [2:0] ded_request,
	input wire logic [3:0] pc_request
);
	import eivs_pkg::*;
	logic cw, vw, sw, la, lb, quiet;
	logic [2:0] cnt_q, cnt_d;
	assign cw = bus_req.write && clk_en && bus_req.address == `EIVS_IDX_CORE;
	assign vw = cw && bus_req.writedata[0];
	assign sw = cw && !bus_req.writedata[0];
	assign la = vector_select && application_lock_bit && !exec_in_boot;
	assign lb = !vector_select && boot_lock_bit && exec_in_boot;
	assign quiet = ded_request == 3'h0 && pc_request == 4'h0;
	// ----
	// window mirror
	// ----
	always_comb begin
		cnt_d = cnt_q;
		if (rst)
			cnt_d = 3'h0;
		else if (vw)
			cnt_d = 3'h4;
		else if (cnt_q != 3'h0 && clk_en)
			cnt_d = cnt_q - 3'h1;
	end
	always_ff @(posedge ref_clk) begin
		cnt_q <= cnt_d;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_vsel_cause: assert property (
		$changed(vector_select) && !$past(rst) |-> $past(sw))
		else $error("select moved without a select write");
	a_vsel_take: assert property (
		vw ##1 sw |=> vector_select == $past(bus_req.writedata[1]))
		else $error("select write in window not taken");
	// cnt_q zero means at least five cycles since the enable write
	a_vsel_locked: assert property (
		sw && cnt_q == 3'h0 |=> $stable(vector_select))
		else $error("select changed outside the window");
	a_gate_open: assert property (
		vw |=> quiet [*2])
		else $error("request during vector change");
	a_lock_app: assert property (
		la && $past(la) |-> quiet)
		else $error("request while application code locked");
	a_lock_boot: assert property (
		lb && $past(lb) |-> quiet)
		else $error("request while boot code locked");
	a_sense_read: assert property (
		bus_req.read && !bus_rsp.waitrequest
		&& bus_req.address == `EIVS_IDX_SENSE
		|-> bus_rsp.readdata[31:6] == 26'h0)
		else $error("sense readback upper bits set");
	a_reset_zero: assert property (
		$fell(rst) |-> !vector_select && quiet)
		else $error("outputs not clear after reset");
endmodule : eivs_props
`default_nettype wire

// >>> verif/test_eivs_top.sv
// Purpose: self-checking bench for the external interrupt block
// Assumes: word-index addresses, pins from eivs_pins
// Notes: request checks wait sync plus flag latency with margin
`timescale 1ns/10ps
`default_nettype none
`include "eivs_map.svh"
module test_eivs_top;
	import eivs_pkg::*;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic insn_retire, exec_in_boot, application_lock_bit, boot_lock_bit;
	logic gie;
	logic vector_select;
	logic [2:0] ded_ack, ded_request, ded_in, ded_wake;
	logic [3:0] pc_request, pc_ack, pc_wake;
	logic [31:0] pc_in;
	eivs_bus_req_type req;
	eivs_bus_rsp_type rsp;
	int n_fail, samples_checked;
	eivs_pins pins (
		.dedicated_irq_inputs(ded_in),
		.pin_change_inputs(pc_in)
	);
	eivs_top DUT (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(1'h1),
		.bus_req(req),
		.bus_rsp(rsp),
		.dedicated_irq_inputs(ded_in),
		.pin_change_inputs(pc_in),
		.global_irq_enable(gie),
		.insn_retire(insn_retire),
		.exec_in_boot(exec_in_boot),
		.application_lock_bit(application_lock_bit),
		.boot_lock_bit(boot_lock_bit),
		.ded_ack(ded_ack),
		.pc_ack(pc_ack),
		.vector_select(vector_select),
		.ded_request(ded_request),
		.pc_request(pc_request),
		.ded_wake(ded_wake),
		.pc_wake(pc_wake)
	);
	always #2 ref_clk = ~ref_clk;
	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %0t saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic idle(input int n);
		req <= '0;
		repeat (n) @(posedge ref_clk);
	endtask : idle
	task automatic dq(input int n, input logic [2:0] e);
		idle(n);
		chk(32'(ded_request), 32'(e));
	endtask : dq
	task automatic pcq(input int n, input logic [3:0] e);
		idle(n);
		chk(32'(pc_request), 32'(e));
	endtask : pcq
	// write stays up so that writes can follow back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{a, 1'h0, 1'h1, {24'h0, d}};
		do
			@(posedge ref_clk);
		while (rsp.waitrequest !== 1'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		req <= '{a, 1'h1, 1'h0, 32'h0};
		do
			@(posedge ref_clk);
		while (rsp.waitrequest !== 1'h0);
		chk(rsp.readdata, {24'h0, e});
	endtask : rd
	task automatic retire;
		insn_retire <= 1'h1;
		idle(1);
		insn_retire <= 1'h0;
	endtask : retire
	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (6000) @(posedge ref_clk);
		n_fail++;
		wrap_up;
	end
	// ----
	// tests
	// ----
	initial begin : main
		int m;
		logic idl;
		req = '0;
		insn_retire = 1'h0;
		exec_in_boot = 1'h0;
		application_lock_bit = 1'h0;
		boot_lock_bit = 1'h0;
		ded_ack = 3'h0;
		gie = 1'h1;
		pc_ack = 4'h0;
		n_fail = 0;
		samples_checked = 0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		idle(1);
		rd(`EIVS_IDX_ENABLE, 8'h00);
		rd(`EIVS_IDX_CORE, 8'h00);
		rd(`EIVS_IDX_SENSE, 8'h00);
		rd(8'h10, 8'h00);
		wr(`EIVS_IDX_SENSE, 8'hff);
		rd(`EIVS_IDX_SENSE, 8'h3f);
		// fall mode idles low so its wrong edge comes first
		for (m = 0; m < 4; m++) begin
			idl = m != 2;
			wr(`EIVS_IDX_ENABLE, 8'h00);
			wr(`EIVS_IDX_SENSE, 8'(m));
			pins.set_ded(0, idl);
			idle(8);
			wr(`EIVS_IDX_EXT_FLAG, 8'h01);
			wr(`EIVS_IDX_ENABLE, 8'h01);
			pins.set_ded(0, !idl);
			dq(8, 3'(m < 2));
			chk(32'(ded_wake), 32'(m < 2));
			if (m > 1) begin
				pins.set_ded(0, idl);
				dq(8, 3'h1);
			end
			if (m == 0) begin
				// global enable low must mask even a standing level
				gie <= 1'h0;
				dq(1, 3'h0);
				gie <= 1'h1;
				rd(`EIVS_IDX_EXT_FLAG, 8'h00);
				pins.set_ded(0, 1'h1);
				idle(8);
			end else begin
				ded_ack <= 3'h1;
				idle(1);
				ded_ack <= 3'h0;
				idle(2);
			end
			chk(32'(ded_request), 32'h0);
		end
		wr(`EIVS_IDX_PC_CTRL, 8'h0f);
		for (m = 0; m < 4; m++)
			wr(`EIVS_IDX_PC_MASK0 + 8'(m), 8'h01);
		for (m = 0; m < 4; m++) begin
			pins.flip_pc(8 * m + 1);
			pcq(8, 4'h0);
			pins.flip_pc(8 * m);
			pcq(8, 4'h1 << m);
			chk(32'(pc_wake), 32'(4'h1 << m));
			wr(`EIVS_IDX_PC_FLAG, 8'h01 << m);
			pcq(2, 4'h0);
		end
		pins.flip_pc(0);
		idle(8);
		wr(`EIVS_IDX_CORE, 8'h01);
		wr(`EIVS_IDX_CORE, 8'h02);
		pcq(2, 4'h0);
		chk(32'(vector_select), 32'h1);
		retire;
		pcq(2, 4'h1);
		wr(`EIVS_IDX_CORE, 8'h03);
		rd(`EIVS_IDX_CORE, 8'h03);
		idle(8);
		rd(`EIVS_IDX_CORE, 8'h02);
		wr(`EIVS_IDX_CORE, 8'h00);
		pcq(2, 4'h1);
		chk(32'(vector_select), 32'h1);
		application_lock_bit <= 1'h1;
		pcq(3, 4'h0);
		exec_in_boot <= 1'h1;
		pcq(3, 4'h1);
		wr(`EIVS_IDX_CORE, 8'h01);
		wr(`EIVS_IDX_CORE, 8'h00);
		retire;
		boot_lock_bit <= 1'h1;
		pcq(3, 4'h0);
		chk(32'(vector_select), 32'h0);
		exec_in_boot <= 1'h0;
		pcq(3, 4'h1);
		// handler taken: the group flag must drop
		pc_ack <= 4'h1;
		idle(1);
		pc_ack <= 4'h0;
		pcq(1, 4'h0);
		chk(32'(pc_wake), 32'h0);
		wrap_up;
	end
endmodule : test_eivs_top
bind eivs_top eivs_props u_props (
	.ref_clk(ref_clk),
	.rst(rst),
	.clk_en(clk_en),
	.bus_req(bus_req),
	.bus_rsp(bus_rsp),
	.exec_in_boot(exec_in_boot),
	.application_lock_bit(application_lock_bit),
	.boot_lock_bit(boot_lock_bit),
	.vector_select(vector_select),
	.ded_request(ded_request),
	.pc_request(pc_request)
);
`default_nettype wire
